// ---- hw/pts_defines.svh ----
// offsets, field positions, reset values and timing counts of the ptp client port
//
// Overview of operation
// - transparent clock adds timer correction to timestamp
// - correction sign bit forced to zero
// - write error flag on tag push failure
// - read error flag on tag pop failure
// - error flags sticky until tx path reset
// - op 00 takes no timestamp
// - op 01 captures and inserts timestamp
// - op 11 behaves as no operation
// - tag ignored for no operation
// - tag returned with timestamp
// - valid high while timestamp presented
// - returned tag equals supplied tag
// - tx timestamp is sop capture time
// - timestamps keep timer bit format
// - rx timestamp is sop capture time
// - rx timestamp valid with sop cycle
// - one-step only while enable set
// - one-step timestamp shifted by latency adjust
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH
`define PTS_ADDR_CTRL 8'h00
`define PTS_ADDR_LAT 8'h04
`define PTS_ADDR_STAT 8'h08
`define PTS_CTRL_TC_BIT 0
`define PTS_CTRL_ONE_BIT 1
`define PTS_CTRL_RST_BIT 2
`define PTS_STAT_WERR_BIT 0
`define PTS_STAT_RERR_BIT 1
`define PTS_STAT_CNT_LSB 2
`define PTS_LAT_RST 11'h000
`define PTS_QDEPTH 4
`define PTS_CLK_PERIOD_NS 4
`define PTS_TC_STEP (64'(`PTS_CLK_PERIOD_NS) << 16)
`define PTS_RESP_OKAY 2'h0
`define PTS_RESP_SLVERR 2'h2
`endif

// ---- hw/pts_pkg.sv ----
// types of the ptp client port
package pts_pkg;
  // per-frame timestamp operation codes
  typedef enum logic [1:0] {
    PTS_OP_NOP = 2'b00,
    PTS_OP_ONE = 2'b01,
    PTS_OP_TWO = 2'b10,
    PTS_OP_RSV = 2'b11
  } pts_op_t;

  // one pending tag queue entry
  typedef struct packed {
    logic one_step;
    logic [15:0] tag;
    logic [15:0] toff;
    logic [15:0] coff;
    logic upd;
  } pts_entry_t;
endpackage

// ---- hw/pts_client_port.sv ----
// ptp timestamp client port with tag queue and axi4-lite control
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "pts_defines.svh"
module pts_client_port
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [79:0] tx_timer_in, // tx system timer
  input wire logic [79:0] rx_timer_in, // rx system timer
  input wire logic tx_sop_in, // frame accepted with op and tag
  input wire pts_pkg::pts_op_t frame_timestamp_op_code, // per-frame op
  input wire logic [15:0] tx_tag_in, // per-frame tag
  input wire logic tx_upd_chksum_in, // update udp checksum
  input wire logic [15:0] tx_tstamp_offset_in, // timestamp byte offset
  input wire logic [15:0] tx_chksum_offset_in, // checksum byte offset
  input wire logic tx_capture_in, // sop crosses capture plane
  input wire logic rx_sop_in, // rx sop on a segment
  output logic tx_tstamp_valid_out, // timestamp presented
  output logic [15:0] tx_tstamp_tag_out, // returned tag
  output logic [79:0] tx_tstamp_out, // two-step timestamp
  output logic ins_valid_out, // one-step insertion request
  output logic [79:0] ins_tstamp_out, // adjusted one-step timestamp
  output logic [15:0] ins_tstamp_offset_out, // where to write it
  output logic [15:0] ins_chksum_offset_out, // checksum location
  output logic ins_upd_chksum_out, // checksum update wanted
  output logic rx_sop_out, // rx sop, aligned with timestamp
  output logic [79:0] rx_tstamp_out, // rx timestamp
  output logic tx_write_error_out, // sticky tag push error
  output logic tx_read_error_out // sticky tag pop error
);
  import pts_pkg::*;

  ////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic tc_mode; // transparent clock mode
    logic one_en; // one-step enable
    logic [10:0] lat; // latency adjust
    logic txrst; // tx path reset pulse
    logic werr, rerr; // sticky push and pop error flags
    pts_entry_t [`PTS_QDEPTH-1:0] q; // tag queue
    logic [1:0] wptr, rptr; // push and pop pointers
    logic [2:0] cnt; // queue fill
    logic [63:0] local_ns; // local residence clock
    logic ts_valid; // timestamp valid
    logic [15:0] tag_out; // returned tag
    logic [79:0] ts_out; // timestamp
    logic ins_valid, ins_upd; // insert request and checksum update
    logic [79:0] ins_ts; // insert timestamp
    logic [15:0] ins_toff, ins_coff; // insert and checksum offsets
    logic rx_sop; // rx sop copy
    logic [79:0] rx_ts; // rx timestamp
    logic awready, wready; // write channel readies
    logic aw_got, w_got; // address and data held
    logic [7:0] wa; // held address
    logic [31:0] wd; // held data
    logic [3:0] ws; // held strobes
    logic bvalid, arready, rvalid; // response valid, read ready, read valid
    logic [1:0] bresp, rresp; // write and read responses
    logic [31:0] rdata; // r data
  } pts_state_t;

  pts_state_t r_reg;
  pts_state_t r_next;

  ////////////////////////////////////////////////////////////////
  // helpers
  // op codes that take a timestamp; nop and reserved do not
  function automatic logic op_takes(input pts_op_t op);
    op_takes = (op == PTS_OP_ONE) || (op == PTS_OP_TWO);
  endfunction

  // register address hit, shared by read and write
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `PTS_ADDR_CTRL) || (a == `PTS_ADDR_LAT) || (a == `PTS_ADDR_STAT);
  endfunction

  // one-step latency shift in the active timer format; normal format has whole
  // nanoseconds only, so the fraction bits of the adjust are dropped there
  function automatic logic [79:0] adj_ts(input logic [79:0] t, input logic tc,
                                          input logic [10:0] l);
    adj_ts = tc ? {16'h0, t[63:0] + {40'h0, l, 13'h0}}
                : {t[79:32], t[31:0] + {24'h0, l[10:3]}};
  endfunction

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic pop;
    logic push_req;
    logic push;
    logic full;
    logic [79:0] base;
    pts_entry_t e;
    base = tx_timer_in;
    r_next = r_reg;
    pop = tx_capture_in && (r_reg.cnt != 3'h0);
    full = (r_reg.cnt == 3'(`PTS_QDEPTH));
    push_req = tx_sop_in && op_takes(frame_timestamp_op_code);
    push = push_req && (!full || pop);
    e = r_reg.q[r_reg.rptr];
    // tc: local clock plus correction, sign forced positive
    if (r_reg.tc_mode)
    begin
      base = {16'h0, r_reg.local_ns + {1'b0, tx_timer_in[62:0]}};
    end
    r_next.local_ns = r_reg.local_ns + `PTS_TC_STEP;
    r_next.txrst = 1'b0;
    // tx path reset empties the queue and drops the flags
    if (r_reg.txrst)
    begin
      r_next.werr = 1'b0;
      r_next.rerr = 1'b0;
      r_next.wptr = 2'h0;
      r_next.rptr = 2'h0;
      r_next.cnt = 3'h0;
    end
    else
    begin
      if (push)
      begin
        // nop frames never reach here so their tag is never stored
        r_next.q[r_reg.wptr].one_step =
          (frame_timestamp_op_code == PTS_OP_ONE) && r_reg.one_en;
        r_next.q[r_reg.wptr].tag = tx_tag_in;
        r_next.q[r_reg.wptr].toff = tx_tstamp_offset_in;
        r_next.q[r_reg.wptr].coff = tx_chksum_offset_in;
        r_next.q[r_reg.wptr].upd = tx_upd_chksum_in;
        r_next.wptr = r_reg.wptr + 2'h1;
      end
      if (pop)
      begin
        r_next.rptr = r_reg.rptr + 2'h1;
      end
      r_next.cnt = r_reg.cnt + {2'h0, push} - {2'h0, pop};
    end
    // flags set after the clear, so an error in the reset cycle is not lost
    if (push_req && !push)
    begin
      r_next.werr = 1'b1;
    end
    if (tx_capture_in && (r_reg.cnt == 3'h0))
    begin
      r_next.rerr = 1'b1;
    end
    // present the popped entry with its timestamp
    r_next.ts_valid = pop && !r_reg.txrst;
    r_next.ins_valid = pop && !r_reg.txrst && e.one_step;
    if (pop)
    begin
      r_next.tag_out = e.tag;
      r_next.ts_out = base;
      r_next.ins_ts = adj_ts(base, r_reg.tc_mode, r_reg.lat);
      r_next.ins_toff = e.toff;
      r_next.ins_coff = e.coff;
      r_next.ins_upd = e.upd;
    end
    // rx timer sampled with the sop so both appear together
    r_next.rx_sop = rx_sop_in;
    r_next.rx_ts = rx_timer_in;
    // axi write address and data, taken in either order
    if (awvalid && r_reg.awready)
    begin
      r_next.aw_got = 1'b1;
      r_next.awready = 1'b0;
      r_next.wa = awaddr;
    end
    if (wvalid && r_reg.wready)
    begin
      r_next.w_got = 1'b1;
      r_next.wready = 1'b0;
      r_next.wd = wdata;
      r_next.ws = wstrb;
    end
    // both halves held: perform write and answer
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid)
    begin
      r_next.bvalid = 1'b1;
      r_next.bresp = addr_ok(r_reg.wa) ? `PTS_RESP_OKAY : `PTS_RESP_SLVERR;
      if ((r_reg.wa == `PTS_ADDR_CTRL) && r_reg.ws[0])
      begin
        r_next.tc_mode = r_reg.wd[`PTS_CTRL_TC_BIT];
        r_next.one_en = r_reg.wd[`PTS_CTRL_ONE_BIT];
        r_next.txrst = r_reg.wd[`PTS_CTRL_RST_BIT];
      end
      if ((r_reg.wa == `PTS_ADDR_LAT) && r_reg.ws[0])
      begin
        r_next.lat[7:0] = r_reg.wd[7:0];
      end
      if ((r_reg.wa == `PTS_ADDR_LAT) && r_reg.ws[1])
      begin
        r_next.lat[10:8] = r_reg.wd[10:8];
      end
    end
    // response taken: reopen both channels
    if (r_reg.bvalid && bready)
    begin
      r_next.bvalid = 1'b0;
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.awready = 1'b1;
      r_next.wready = 1'b1;
    end
    // axi read, one outstanding
    if (arvalid && r_reg.arready)
    begin
      r_next.arready = 1'b0;
      r_next.rvalid = 1'b1;
      r_next.rresp = addr_ok(araddr) ? `PTS_RESP_OKAY : `PTS_RESP_SLVERR;
      r_next.rdata = 32'h0;
      if (araddr == `PTS_ADDR_CTRL)
      begin
        r_next.rdata[`PTS_CTRL_TC_BIT] = r_reg.tc_mode;
        r_next.rdata[`PTS_CTRL_ONE_BIT] = r_reg.one_en;
      end
      else if (araddr == `PTS_ADDR_LAT)
      begin
        r_next.rdata[10:0] = r_reg.lat;
      end
      else if (araddr == `PTS_ADDR_STAT)
      begin
        r_next.rdata[`PTS_STAT_WERR_BIT] = r_reg.werr;
        r_next.rdata[`PTS_STAT_RERR_BIT] = r_reg.rerr;
        r_next.rdata[`PTS_STAT_CNT_LSB +: 3] = r_reg.cnt;
      end
    end
    if (r_reg.rvalid && rready)
    begin
      r_next.rvalid = 1'b0;
      r_next.arready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_reg <= '0;
      r_reg.lat <= `PTS_LAT_RST;
      r_reg.awready <= 1'b1;
      r_reg.wready <= 1'b1;
      r_reg.arready <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register
  assign {awready, wready, arready} = {r_reg.awready, r_reg.wready, r_reg.arready};
  assign {bvalid, bresp} = {r_reg.bvalid, r_reg.bresp};
  assign {rvalid, rdata, rresp} = {r_reg.rvalid, r_reg.rdata, r_reg.rresp};
  assign {tx_tstamp_valid_out, tx_tstamp_tag_out} = {r_reg.ts_valid, r_reg.tag_out};
  assign tx_tstamp_out = r_reg.ts_out;
  assign {ins_valid_out, ins_tstamp_out} = {r_reg.ins_valid, r_reg.ins_ts};
  assign {ins_tstamp_offset_out, ins_chksum_offset_out} = {r_reg.ins_toff, r_reg.ins_coff};
  assign ins_upd_chksum_out = r_reg.ins_upd;
  assign {rx_sop_out, rx_tstamp_out} = {r_reg.rx_sop, r_reg.rx_ts};
  assign {tx_write_error_out, tx_read_error_out} = {r_reg.werr, r_reg.rerr};

  ////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_nop_skip;
    (tx_sop_in && !op_takes(frame_timestamp_op_code) && !tx_capture_in && !r_reg.txrst)
      |=> (r_reg.cnt == $past(r_reg.cnt));
  endproperty
  a_nop_skip: assert property (p_nop_skip) else $error("nop frame changed queue");
  property p_push;
    (tx_sop_in && op_takes(frame_timestamp_op_code) && (r_reg.cnt < 3'(`PTS_QDEPTH))
      && !tx_capture_in && !r_reg.txrst) |=> (r_reg.cnt == $past(r_reg.cnt) + 3'h1);
  endproperty
  a_push: assert property (p_push) else $error("timestamp frame not queued");
  property p_valid;
    (tx_capture_in && (r_reg.cnt != 3'h0) && !r_reg.txrst) |=> tx_tstamp_valid_out;
  endproperty
  a_valid: assert property (p_valid) else $error("timestamp valid missing");
  property p_tag;
    (tx_capture_in && (r_reg.cnt != 3'h0))
      |=> (tx_tstamp_tag_out == $past(r_reg.q[r_reg.rptr].tag));
  endproperty
  a_tag: assert property (p_tag) else $error("returned tag mismatch");
  property p_werr;
    (tx_sop_in && op_takes(frame_timestamp_op_code) && (r_reg.cnt == 3'(`PTS_QDEPTH))
      && !tx_capture_in && !r_reg.txrst) |=> tx_write_error_out;
  endproperty
  a_werr: assert property (p_werr) else $error("write error not raised");
  property p_rerr;
    (tx_capture_in && (r_reg.cnt == 3'h0) && !r_reg.txrst) |=> tx_read_error_out;
  endproperty
  a_rerr: assert property (p_rerr) else $error("read error not raised");
  property p_sticky;
    (tx_write_error_out && !r_reg.txrst) |=> tx_write_error_out;
  endproperty
  a_sticky: assert property (p_sticky) else $error("write error cleared");
  property p_rx;
    rx_sop_in |=> (rx_sop_out && (rx_tstamp_out == $past(rx_timer_in)));
  endproperty
  a_rx: assert property (p_rx) else $error("rx timestamp not aligned");
  property p_ins;
    ins_valid_out |-> (tx_tstamp_valid_out && r_reg.one_en);
  endproperty
  a_ins: assert property (p_ins) else $error("insert without timestamp");
  c_two_step: cover property (tx_sop_in && frame_timestamp_op_code == PTS_OP_TWO
    ##[1:20] tx_tstamp_valid_out);
  c_one_step: cover property (ins_valid_out && ins_upd_chksum_out);
  c_werr: cover property ($rose(tx_write_error_out));
  c_rx: cover property (rx_sop_out);
endmodule

// ---- test/pts_client_model.sv ----
// client-side model: system timers and per-frame ptp requests
`timescale 1ns/1ps
module pts_client_model
(
  input wire logic aclk, // system clock
  output logic [79:0] tx_timer_in, // tx system timer
  output logic [79:0] rx_timer_in, // rx system timer
  output logic tx_sop_in, // frame accepted
  output pts_pkg::pts_op_t frame_timestamp_op_code, // per-frame op
  output logic [15:0] tx_tag_in, // per-frame tag
  output logic tx_upd_chksum_in, // checksum update request
  output logic [15:0] tx_tstamp_offset_in, // timestamp offset
  output logic [15:0] tx_chksum_offset_in // checksum offset
);
  import pts_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  logic [47:0] sec_reg = 48'h0; // seconds field
  // start 640 cycles before a rollover; the bench ends sooner, so no seconds carry is exercised
  logic [31:0] ns_reg = 32'h3b9ac000;

  // timer advances one clock period per cycle, nanoseconds roll into seconds
  always @(posedge aclk)
  begin
    if (ns_reg >= 32'h3b9ac9fc)
    begin
      ns_reg <= 32'h0;
      sec_reg <= sec_reg + 48'h1;
    end
    else
      ns_reg <= ns_reg + 32'h4;
  end
  // seconds stay small, so bit 63 is clear when the timer is a correction
  assign tx_timer_in = {sec_reg, ns_reg};
  assign rx_timer_in = {sec_reg + 48'h5, ns_reg};

  //////////////////////////////////////////////////////////////////////////////
  // idle frame lines at time zero
  initial
  begin
    tx_sop_in = 1'b0;
    frame_timestamp_op_code = PTS_OP_NOP;
    {tx_tag_in, tx_upd_chksum_in, tx_tstamp_offset_in, tx_chksum_offset_in} = '0;
  end

  // one frame per call; back-to-back calls keep the strobe high
  task automatic send(input pts_op_t op, input logic [15:0] tag, input logic [15:0] toff,
                      input logic [15:0] coff, input logic upd);
    tx_sop_in <= 1'b1;
    frame_timestamp_op_code <= op;
    tx_tag_in <= tag;
    tx_tstamp_offset_in <= toff;
    tx_chksum_offset_in <= coff;
    tx_upd_chksum_in <= upd;
    @(posedge aclk);
  endtask

  // released lines show inverted junk, never the last good value
  task automatic idle;
    tx_sop_in <= 1'b0;
    frame_timestamp_op_code <= pts_op_t'(~frame_timestamp_op_code);
    tx_tag_in <= ~tx_tag_in;
    tx_tstamp_offset_in <= ~tx_tstamp_offset_in;
    tx_chksum_offset_in <= ~tx_chksum_offset_in;
    tx_upd_chksum_in <= ~tx_upd_chksum_in;
    @(posedge aclk);
  endtask
endmodule

// ---- test/tb_ptp_timestamp_client_port.sv ----
// self-checking bench of the ptp client port
`timescale 1ns/1ps
`include "pts_defines.svh"
module tb_ptp_timestamp_client_port;
  import pts_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready; // bus drives
  logic tx_capture_in, rx_sop_in, one_en, tc; // event strobes, mode copies
  logic [31:0] rd; // read data taken by the bench
  logic [63:0] lns; // copy of the local residence clock
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, tx_tstamp_valid_out, ins_valid_out;
  logic rx_sop_out, ins_upd_chksum_out, tx_write_error_out, tx_read_error_out;
  logic tx_sop_in, tx_upd_chksum_in;
  logic [15:0] tx_tag_in, tx_tstamp_offset_in, tx_chksum_offset_in, tx_tstamp_tag_out;
  logic [15:0] ins_tstamp_offset_out, ins_chksum_offset_out;
  logic [79:0] tx_timer_in, rx_timer_in, tx_tstamp_out, ins_tstamp_out, rx_tstamp_out, ts;
  pts_op_t frame_timestamp_op_code;
  logic [10:0] lat; // latency adjust written to the device
  int failures, cmp_count, k;
  pts_entry_t q[$]; // frames expected back, oldest first

  pts_client_port dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .tx_timer_in, .rx_timer_in, .tx_sop_in,
    .frame_timestamp_op_code, .tx_tag_in, .tx_upd_chksum_in, .tx_tstamp_offset_in,
    .tx_chksum_offset_in, .tx_capture_in, .rx_sop_in, .tx_tstamp_valid_out,
    .tx_tstamp_tag_out, .tx_tstamp_out, .ins_valid_out, .ins_tstamp_out,
    .ins_tstamp_offset_out, .ins_chksum_offset_out, .ins_upd_chksum_out, .rx_sop_out,
    .rx_tstamp_out, .tx_write_error_out, .tx_read_error_out);
  pts_client_model cli_u (.aclk, .tx_timer_in, .rx_timer_in, .tx_sop_in,
    .frame_timestamp_op_code, .tx_tag_in, .tx_upd_chksum_in, .tx_tstamp_offset_in,
    .tx_chksum_offset_in);

  // 250 MHz clock
  always #2 aclk = ~aclk;

  // local residence clock as the device keeps it, cleared by reset only
  always @(posedge aclk) lns <= aresetn ? lns + `PTS_TC_STEP : 64'h0;

  //////////////////////////////////////////////////////////////////////////////
  // single compare point
  task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // axi write: address and data together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'b111;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // axi read: rready held until data arrives
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    {d, rs} = {rdata, rresp};
    rready <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // one random frame; only one- and two-step frames join the queue
  task automatic tx(input logic [1:0] op);
    pts_entry_t e;
    e = pts_entry_t'(50'({$urandom, $urandom}));
    e.one_step = (op == 2'b01) && one_en;
    cli_u.send(pts_op_t'(op), e.tag, e.toff, e.coff, e.upd);
    if ((op == 2'b01 || op == 2'b10) && q.size() < 4) q.push_back(e);
  endtask

  // n back-to-back captures, each result checked one edge later
  task automatic drain(input int n);
    pts_entry_t e;
    logic have;
    logic [79:0] t;
    {have, t, e} = '0;
    tx_capture_in <= 1'b1;
    for (int i = 0; i <= n; i++)
    begin
      @(posedge aclk);
      if (i > 0)
      begin
        chk("ts_valid", tx_tstamp_valid_out, have);
        if (have)
        begin
          chk("ts_tag", tx_tstamp_tag_out, e.tag);
          chk("ts_time", tx_tstamp_out, t);
          chk("ins_valid", ins_valid_out, e.one_step);
          if (e.one_step)
          begin
            chk("ins_time", ins_tstamp_out, tc ? {16'h0, t[63:0] + {40'h0, lat, 13'h0}}
                : {t[79:32], t[31:0] + 32'(lat[10:3])});
            chk("ins_where", {ins_tstamp_offset_out, ins_chksum_offset_out,
                ins_upd_chksum_out}, {e.toff, e.coff, e.upd});
          end
        end
      end
      have = (i < n) && (q.size() > 0);
      if (have) e = q.pop_front();
      t = tc ? {16'h0, lns + {1'b0, tx_timer_in[62:0]}} : tx_timer_in;
      if (i == n - 1) tx_capture_in <= 1'b0;
    end
  endtask

  // mode write, optionally with the tx path reset pulse
  task automatic mode(input logic en, input logic rst);
    one_en = en;
    axi_wr(`PTS_ADDR_CTRL, {29'h0, rst, en, tc}, r);
    if (rst)
    begin
      repeat (2) @(posedge aclk);
      q.delete();
      chk("err_clear", {tx_write_error_out, tx_read_error_out}, 2'b00);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic results;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog well beyond the fewer than two hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    results();
  end

  // main sequence
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {tx_capture_in, rx_sop_in, one_en, tc, awaddr, araddr, wdata, wstrb} = '0;
    {failures, cmp_count} = '0;
    void'($urandom(32'ha9a2));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("rst_ready", {awready, wready, arready, bvalid, rvalid}, 5'b11100);
    chk("rst_err", {tx_write_error_out, tx_read_error_out}, 2'b00);
    // registers: latency read back, unmapped places refused
    lat = 11'($urandom);
    axi_wr(`PTS_ADDR_LAT, {21'h0, lat}, r);
    chk("lat_wr", r, `PTS_RESP_OKAY);
    axi_rd(`PTS_ADDR_LAT, rd, r);
    chk("lat_rd", rd[10:0], lat);
    axi_wr(8'h0c, 32'hffff_ffff, r);
    chk("bad_wr", r, `PTS_RESP_SLVERR);
    axi_rd(8'h10, rd, r);
    chk("bad_rd", {rd, r}, {32'h0, `PTS_RESP_SLVERR});
    mode(1'b1, 1'b0);
    // every op code; nop and reserved leave the capture unmatched
    for (int op = 0; op < 4; op++)
    begin
      tx(2'(op));
      cli_u.idle();
      drain(1);
    end
    chk("op_rerr", tx_read_error_out, 1'b1);
    mode(1'b1, 1'b1);
    // random bursts of mixed one- and two-step frames
    repeat (4)
    begin
      k = 1 + $urandom % 4;
      repeat (k) tx(($urandom % 2) ? 2'b01 : 2'b10);
      cli_u.idle();
      drain(k);
    end
    // overfill, then over-drain: both flags stick
    repeat (5) tx(2'b10);
    cli_u.idle();
    chk("werr", tx_write_error_out, 1'b1);
    drain(5);
    chk("rerr", {tx_write_error_out, tx_read_error_out}, 2'b11);
    // status word: both flags up, queue empty again
    axi_rd(`PTS_ADDR_STAT, rd, r);
    chk("stat", {rd[4:0], r}, {5'b00011, `PTS_RESP_OKAY});
    mode(1'b0, 1'b1);
    // one-step disabled: timestamp returned, no insertion
    tx(2'b01);
    cli_u.idle();
    drain(1);
    // transparent clock: the timer is a correction the client has already
    // adjusted, and the local residence clock is added to it
    tc = 1'b1;
    mode(1'b1, 1'b1);
    repeat (3) tx(2'b01);
    cli_u.idle();
    drain(3);
    // rx timestamp follows sop
    repeat (3)
    begin
      rx_sop_in <= 1'b1;
      @(posedge aclk);
      ts = rx_timer_in;
      rx_sop_in <= 1'b0;
      @(posedge aclk);
      chk("rx_sop", rx_sop_out, 1'b1);
      chk("rx_time", rx_tstamp_out, ts);
      repeat ($urandom % 3) @(posedge aclk);
    end
    results();
  end
endmodule
